// *** rtl/seipol_pkg.sv ***
// seipol_pkg: constants and carrier types of the servo enable and input polarity block
// assumes one 25 MHz clock and a plain register port driven by a terminal command decoder
// How it works
// - emergency stop closed-contact default; open raises F4
// - over-travel inputs closed-contact default; open alarms
// - polarity writes ignored while servo enabled
// - polarity value zero selects normally open
// - port index 0 stop, 2 plus, 3 minus
// - port read gives function, timer, polarity
// - stop alarm shows F then 4
// - motion at power-up raises A1
// - ready valid about three seconds after power-on
// - servo state output closed while enabled
// - motor-off command disables servo
// - servo-on command re-enables servo
// - any alarm opens driver ready
// - alarm cleared by input or command
package seipol_pkg;
	// ***************************************************
	// register map
	// ***************************************************
	localparam logic [3:0] REG_CMD    = 4'h0; // write: bit0 motor off, bit1 servo on, bit2 clear
	localparam logic [3:0] REG_PSEL   = 4'h1; // input port select index
	localparam logic [3:0] REG_PORT   = 4'h2; // selected port settings
	localparam logic [3:0] REG_STATUS = 4'h3; // live state
	localparam logic [3:0] REG_IRQ    = 4'h4; // sticky events, write one to clear
	localparam logic [3:0] REG_MASK   = 4'h5; // interrupt mask
	localparam logic [3:0] REG_ALARM  = 4'h6; // current alarm code, two characters
	localparam logic [1:0] PORT_ESTOP = 2'h0;
	localparam logic [1:0] PORT_OTP   = 2'h2;
	localparam logic [1:0] PORT_OT_MINUS = 2'h3;
	// port word: [15:8] function, [7:1] anti-chatter timer in ms, [0] polarity
	localparam int        POL_BIT     = 0;
	localparam int        FILT_LSB    = 1;
	localparam int        FUNC_LSB    = 8;
	localparam logic      POL_NC      = 1'b1; // 1 closed contact, 0 open contact
	localparam logic [6:0] FILT_RST   = 7'h01;
	localparam logic [7:0] FUNC_RST_ESTOP    = 8'h01;
	localparam logic [7:0] FUNC_RST_OTP      = 8'h02;
	localparam logic [7:0] FUNC_RST_OT_MINUS = 8'h03;
	// filtered levels start at the closed idle level so reset raises no false alarm
	localparam logic [3:0] LEVEL_RST  = 4'hd;
	// alarm display characters
	localparam logic [7:0] CH_F   = 8'h46;
	localparam logic [7:0] CH_4   = 8'h34;
	localparam logic [7:0] CH_A   = 8'h41;
	localparam logic [7:0] CH_1   = 8'h31;
	localparam logic [7:0] CH_O   = 8'h4f;
	localparam logic [7:0] CH_T   = 8'h54;
	// timing
	localparam int CLK_HZ         = 25_000_000;
	localparam int READY_MS       = 3000;
	localparam int READY_CYC      = READY_MS * (CLK_HZ / 1000);
	localparam int MS_CYC         = CLK_HZ / 1000;
	localparam int SEG_MS         = 500; // display alternation period
	localparam int SEG_CYC        = SEG_MS * (CLK_HZ / 1000);
	// events
	localparam int EV_ESTOP = 0;
	localparam int EV_OT    = 1;
	localparam int EV_ABS   = 2;
	localparam int EV_READY = 3;
	localparam int EV_N     = 4;
	typedef struct packed {
		logic [7:0] func;
		logic [6:0] filt;
		logic       pol;
	} seipol_port_s;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} seipol_bus_s;
endpackage : seipol_pkg

// *** rtl/seipol_top.sv ***
// seipol_top: servo enable sequencing, safety input supervision and alarm display
// assumes raw pins async to CLK; bus strobes come from logic on CLK
module seipol_top
	import seipol_pkg::*;
#(
	parameter int READY_CYCLES = READY_CYC,
	parameter int MS_CYCLES    = MS_CYC,
	parameter int SEG_CYCLES   = SEG_CYC
)(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	input  wire logic        EMERGENCY_STOP_INPUT,
	input  wire logic        OVERTRAVEL_PLUS_INPUT,
	input  wire logic        OVERTRAVEL_MINUS_INPUT,
	input  wire logic        SERVO_ENABLE_REQUEST,
	input  wire logic        ALARM_CLEAR_INPUT,
	input  wire logic        MOTOR_MOVING,
	input  wire seipol_pkg::seipol_bus_s BUS,
	output logic      [15:0] RDATA,
	output logic             DRIVER_READY_OUTPUT,
	output logic             SERVO_STATE_OUTPUT,
	output logic      [7:0]  SEG_CHAR,
	output logic             IRQ
);
	import seipol_pkg::*;

	// ***************************************************
	// pin synchronisers
	// ***************************************************
	logic [5:0] s1_q;
	logic [5:0] s2_q;
	// first stage feeds only the second
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
		end
		else if (CE)
		begin
			s1_q <= {MOTOR_MOVING, ALARM_CLEAR_INPUT, SERVO_ENABLE_REQUEST,
				OVERTRAVEL_MINUS_INPUT, OVERTRAVEL_PLUS_INPUT, EMERGENCY_STOP_INPUT};
			s2_q <= s1_q;
		end
	end

	// ***************************************************
	// port settings
	// ***************************************************
	seipol_port_s port_q [4];
	logic [1:0]   psel_q;
	logic         servo_q;
	logic         wr_port;
	assign wr_port = BUS.wr && (BUS.addr == REG_PORT);
	// polarity frozen while servo runs, function and timer always writable
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			port_q[0] <= '{func: FUNC_RST_ESTOP, filt: FILT_RST, pol: POL_NC};
			port_q[1] <= '{func: 8'h00, filt: FILT_RST, pol: POL_NC};
			port_q[2] <= '{func: FUNC_RST_OTP, filt: FILT_RST, pol: POL_NC};
			port_q[3] <= '{func: FUNC_RST_OT_MINUS, filt: FILT_RST, pol: POL_NC};
			psel_q    <= PORT_ESTOP;
		end
		else if (CE)
		begin
			if (BUS.wr && BUS.addr == REG_PSEL)
				psel_q <= BUS.wdata[1:0];
			if (wr_port)
			begin
				port_q[psel_q].func <= BUS.wdata[FUNC_LSB +: 8];
				port_q[psel_q].filt <= BUS.wdata[FILT_LSB +: 7];
				if (!servo_q)
					port_q[psel_q].pol <= BUS.wdata[POL_BIT];
			end
		end
	end

	// ***************************************************
	// debounce and contact polarity
	// ***************************************************
	logic [3:0]  raw;
	logic [3:0]  stab_q;
	logic [15:0] msdiv_q;
	logic        ms_tick;
	logic [6:0]  cnt_q [4];
	assign raw     = {s2_q[2], s2_q[1], 1'b0, s2_q[0]}; // indexed like the port settings
	assign ms_tick = (msdiv_q == 16'(MS_CYCLES - 1));
	// shared millisecond tick keeps four counters narrow
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			msdiv_q <= 16'h0000;
		else if (CE)
			msdiv_q <= ms_tick ? 16'h0000 : msdiv_q + 16'h0001;
	end
	// level accepted only once stable for the port timer
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			stab_q <= LEVEL_RST;
			for (int i = 0; i < 4; i++)
				cnt_q[i] <= 7'h00;
		end
		else if (CE)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (raw[i] == stab_q[i])
					cnt_q[i] <= 7'h00;
				else if (ms_tick)
				begin
					if (cnt_q[i] + 7'h01 >= port_q[i].filt)
					begin
						stab_q[i] <= raw[i];
						cnt_q[i]  <= 7'h00;
					end
					else
						cnt_q[i] <= cnt_q[i] + 7'h01;
				end
			end
		end
	end
	// closed contact: an open (low) pin is active; open contact: a high pin is active
	logic act_estop;
	logic act_otp;
	logic act_ot_minus;
	assign act_estop    = port_q[0].pol ? !stab_q[0] : stab_q[0];
	assign act_otp      = port_q[2].pol ? !stab_q[2] : stab_q[2];
	assign act_ot_minus = port_q[3].pol ? !stab_q[3] : stab_q[3];

	// ***************************************************
	// power-up sequencing and alarms
	// ***************************************************
	logic [31:0] pwr_q;
	logic        ready_done;
	logic        al_estop_q;
	logic        al_ot_q;
	logic        al_abs_q;
	logic        clr;
	logic        any_alarm;
	assign ready_done = (pwr_q == 32'(READY_CYCLES));
	assign clr = s2_q[4] || (BUS.wr && BUS.addr == REG_CMD && BUS.wdata[2]);
	assign any_alarm = al_estop_q || al_ot_q || al_abs_q;
	// self-check window after power-on
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			pwr_q <= 32'h0000_0000;
		else if (CE && !ready_done)
			pwr_q <= pwr_q + 32'h0000_0001;
	end
	// alarms latch; clear drops them only if the cause is gone
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			al_estop_q <= 1'b0;
			al_ot_q    <= 1'b0;
			al_abs_q   <= 1'b0;
		end
		else if (CE)
		begin
			if (act_estop)
				al_estop_q <= 1'b1;
			else if (clr)
				al_estop_q <= 1'b0;
			if (act_otp || act_ot_minus)
				al_ot_q <= 1'b1;
			else if (clr)
				al_ot_q <= 1'b0;
			if (!ready_done && s2_q[5])
				al_abs_q <= 1'b1;
			else if (clr)
				al_abs_q <= 1'b0;
		end
	end

	// ***************************************************
	// servo enable
	// ***************************************************
	logic req_q;
	logic cmd_off;
	logic cmd_on;
	assign cmd_off = BUS.wr && BUS.addr == REG_CMD && BUS.wdata[0];
	assign cmd_on  = BUS.wr && BUS.addr == REG_CMD && BUS.wdata[1];
	// pin enable acts on its rising edge so a terminal motor-off sticks
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			servo_q <= 1'b0;
			req_q   <= 1'b0;
		end
		else if (CE)
		begin
			req_q <= s2_q[3];
			if (any_alarm || !ready_done || cmd_off || (req_q && !s2_q[3]))
				servo_q <= 1'b0;
			else if (cmd_on || (s2_q[3] && !req_q))
				servo_q <= 1'b1;
		end
	end
	// outputs registered
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			DRIVER_READY_OUTPUT <= 1'b0;
			SERVO_STATE_OUTPUT  <= 1'b0;
		end
		else if (CE)
		begin
			DRIVER_READY_OUTPUT <= ready_done && !any_alarm;
			SERVO_STATE_OUTPUT  <= servo_q;
		end
	end

	// ***************************************************
	// seven-segment sequence
	// ***************************************************
	logic [31:0] seg_q;
	logic        phase_q;
	logic [15:0] code;
	always_comb
	begin
		code = 16'h0000;
		if (al_estop_q)
			code = {CH_F, CH_4};
		else if (al_abs_q)
			code = {CH_A, CH_1};
		else if (al_ot_q)
			code = {CH_O, CH_T};
	end
	// first character shown first when an alarm appears while no other alarm is pending
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			seg_q    <= 32'h0000_0000;
			phase_q  <= 1'b0;
			SEG_CHAR <= 8'h00;
		end
		else if (CE)
		begin
			if (code == 16'h0000)
			begin
				seg_q   <= 32'h0000_0000;
				phase_q <= 1'b0;
			end
			else if (seg_q == 32'(SEG_CYCLES - 1))
			begin
				seg_q   <= 32'h0000_0000;
				phase_q <= !phase_q;
			end
			else
				seg_q <= seg_q + 32'h0000_0001;
			SEG_CHAR <= phase_q ? code[7:0] : code[15:8];
		end
	end

	// ***************************************************
	// interrupts and read port
	// ***************************************************
	logic [EV_N-1:0] ev;
	logic [EV_N-1:0] irq_q;
	logic [EV_N-1:0] mask_q;
	logic            rdy_q;
	assign ev = {ready_done && !rdy_q, al_abs_q, al_ot_q, al_estop_q};
	// set wins over clear so no event is lost
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			irq_q  <= '0;
			mask_q <= '0;
			rdy_q  <= 1'b0;
			IRQ    <= 1'b0;
		end
		else if (CE)
		begin
			rdy_q <= ready_done;
			if (BUS.wr && BUS.addr == REG_MASK)
				mask_q <= BUS.wdata[EV_N-1:0];
			irq_q <= ev | (irq_q & ~((BUS.wr && BUS.addr == REG_IRQ) ?
				BUS.wdata[EV_N-1:0] : '0));
			IRQ <= |(irq_q & mask_q);
		end
	end
	// read data valid the cycle after the strobe only
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			RDATA <= 16'h0000;
		else if (CE)
		begin
			RDATA <= 16'h0000;
			if (BUS.rd)
			begin
				unique case (BUS.addr)
					REG_PSEL:   RDATA <= {14'h0000, psel_q};
					REG_PORT:   RDATA <= port_q[psel_q];
					REG_STATUS: RDATA <= {9'h000, act_ot_minus, act_otp, act_estop,
						DRIVER_READY_OUTPUT, servo_q, ready_done, any_alarm};
					REG_IRQ:    RDATA <= {12'h000, irq_q};
					REG_MASK:   RDATA <= {12'h000, mask_q};
					REG_ALARM:  RDATA <= code;
					default:    RDATA <= 16'h0000;
				endcase
			end
		end
	end
endmodule // seipol_top

// *** test/seipol_props.sv ***
// seipol_props: port checks of seipol_top
// assumes CE held high, so no cycle is frozen
module seipol_props
	import seipol_pkg::*;
#(
	parameter int READY_CYCLES = READY_CYC
)(
	input wire logic                    CLK,
	input wire logic                    RST_N,
	input wire seipol_pkg::seipol_bus_s BUS,
	input wire logic [15:0]             RDATA,
	input wire logic                    DRIVER_READY_OUTPUT,
	input wire logic                    SERVO_STATE_OUTPUT,
	input wire logic [7:0]              SEG_CHAR
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_q;
	// ************
	// checks
	// ************
	// cycles since reset release; saturates so a long run cannot wrap
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			cnt_q <= 0;
		else if (cnt_q < READY_CYCLES)
			cnt_q <= cnt_q + 1;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	sequence s_wcmd(logic [1:0] v);
		BUS.wr && BUS.addr == REG_CMD && BUS.wdata[1:0] == v;
	endsequence
	sequence s_f_left;
		SEG_CHAR == CH_F ##1 SEG_CHAR != CH_F;
	endsequence
	property p_rd_idle;
		!$past(BUS.rd) |-> RDATA == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_alarm_rdy;
		(SEG_CHAR != 8'h00) [*2] |-> !DRIVER_READY_OUTPUT;
	endproperty
	a_alarm_rdy: assert property (p_alarm_rdy) else $error("ready during alarm");
	property p_rdy_wait;
		DRIVER_READY_OUTPUT |-> cnt_q >= READY_CYCLES - 2;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("ready too early");
	property p_srv_rise;
		$rose(SERVO_STATE_OUTPUT) |-> DRIVER_READY_OUTPUT;
	endproperty
	a_srv_rise: assert property (p_srv_rise) else $error("servo on while not ready");
	property p_srv_cmd;
		s_wcmd(2'h2) ##0 (DRIVER_READY_OUTPUT && SEG_CHAR == 8'h00) |-> ##2 SERVO_STATE_OUTPUT;
	endproperty
	a_srv_cmd: assert property (p_srv_cmd) else $error("servo command ignored");
	property p_off_cmd;
		s_wcmd(2'h1) |-> ##2 !SERVO_STATE_OUTPUT;
	endproperty
	a_off_cmd: assert property (p_off_cmd) else $error("motor off ignored");
	property p_f_then_4;
		s_f_left |-> SEG_CHAR == CH_4 || SEG_CHAR == 8'h00;
	endproperty
	a_f_then_4: assert property (p_f_then_4) else $error("bad char after F");
	property p_rdy_drop;
		$fell(DRIVER_READY_OUTPUT) |-> ##[0:2] !SERVO_STATE_OUTPUT;
	endproperty
	a_rdy_drop: assert property (p_rdy_drop) else $error("servo kept on");
endmodule // seipol_props
bind seipol_top seipol_props #(.READY_CYCLES(READY_CYCLES)) u_props (.*);

// *** test/seipol_ctrl.sv ***
// seipol_ctrl: user's controller on the parallel control pins
// assumes wanted levels: stop, otp, otm, servo, clear, moving
module seipol_ctrl (
	input  wire logic       clk,
	input  wire logic       ready,
	input  wire logic [5:0] want,
	output logic      [5:0] pins = 6'h06
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************
	// pin drive
	// ************
	// pins move just after an edge; the request waits for ready
	always @(posedge clk)
	begin
		pins[2:0] <= want[2:0];
		pins[3]   <= want[3] && ready;
		pins[5:4] <= want[5:4];
	end
endmodule // seipol_ctrl

// *** test/servo_enable_and_input_polarity_test.sv ***
// servo_enable_and_input_polarity_test: self-checking bench of seipol_top
// assumes shortened counts: ready 50, ms tick 4 cycles
module servo_enable_and_input_polarity_test
	import seipol_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEB = 16; // sync plus one ms tick of filter, with margin
	logic        clk      = 1'b0;
	logic        rst_n    = 1'b0;
	logic [5:0]  want     = 6'h06; // stop open, travel closed
	logic [5:0]  pins;
	seipol_bus_s bus      = '0;
	logic [15:0] rdata;
	logic [15:0] got;
	logic        ready;
	logic        servo_st;
	logic [7:0]  seg;
	logic        irq;
	int          failures = 0;
	int          n_checks = 0;
	// ************
	// harness
	// ************
	always #20 clk = ~clk;
	seipol_ctrl u_ctrl (.clk(clk), .ready(ready), .want(want), .pins(pins));
	seipol_top #(.READY_CYCLES(50), .MS_CYCLES(4), .SEG_CYCLES(8)) dut (
		.CLK(clk), .RST_N(rst_n), .CE(1'b1), .EMERGENCY_STOP_INPUT(pins[0]),
		.OVERTRAVEL_PLUS_INPUT(pins[1]), .OVERTRAVEL_MINUS_INPUT(pins[2]),
		.SERVO_ENABLE_REQUEST(pins[3]), .ALARM_CLEAR_INPUT(pins[4]),
		.MOTOR_MOVING(pins[5]), .BUS(bus), .RDATA(rdata), .DRIVER_READY_OUTPUT(ready),
		.SERVO_STATE_OUTPUT(servo_st), .SEG_CHAR(seg), .IRQ(irq));
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task rd(input logic [3:0] a);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 got = rdata;
	endtask
	task dly(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// looks 1 ns after each edge so the launching edge has settled
	task till(input logic pick_srv, input logic lvl);
		for (int i = 0; i < 200; i++)
			if ((pick_srv ? servo_st : ready) !== lvl)
				dly(1);
	endtask
	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ************
	// scenarios
	// ************
	task t_stop;
		for (int i = 0; i < 40 && seg !== CH_F; i++)
			dly(1);
		for (int i = 0; i < 20 && seg === CH_F; i++)
			dly(1);
		chk({8'h00, seg}, {8'h00, CH_4});
		rd(REG_ALARM);
		chk(got, {CH_F, CH_4});
		wr(REG_PSEL, 16'h0000);
		rd(REG_PORT);
		chk(got, {FUNC_RST_ESTOP, FILT_RST, POL_NC});
		wr(REG_PORT, {FUNC_RST_ESTOP, FILT_RST, 1'b0});
		wr(REG_CMD, 16'h0004);
		dly(2);
		rd(REG_ALARM);
		chk(got, 16'h0000);
		rd(REG_IRQ);
		chk(got & 16'h0007, 16'h0001);
		wr(REG_MASK, 16'h0001);
		dly(2);
		chk({15'h0000, irq}, 16'h0001);
		wr(REG_IRQ, 16'h000f);
		dly(2);
		chk({15'h0000, irq}, 16'h0000);
		rd(4'hf);
		chk(got, 16'h0000);
		$display("t_stop done");
	endtask
	task t_ready;
		till(1'b0, 1'b1);
		rd(REG_STATUS);
		chk(got & 16'h000f, 16'h000a);
		$display("t_ready done");
	endtask
	task t_ot;
		wr(REG_PSEL, 16'h0002);
		rd(REG_PORT);
		chk(got, {FUNC_RST_OTP, FILT_RST, POL_NC});
		wr(REG_PSEL, 16'h0003);
		rd(REG_PORT);
		chk(got, {FUNC_RST_OT_MINUS, FILT_RST, POL_NC});
		want[2] <= 1'b0;
		dly(DEB);
		rd(REG_STATUS);
		chk(got & 16'h0049, 16'h0041);
		want[2] <= 1'b1;
		dly(DEB);
		want[4] <= 1'b1;
		dly(DEB);
		want[4] <= 1'b0;
		till(1'b0, 1'b1);
		chk({15'h0000, ready}, 16'h0001);
		$display("t_ot done");
	endtask
	task t_servo;
		want[3] <= 1'b1;
		till(1'b1, 1'b1);
		chk({15'h0000, servo_st}, 16'h0001);
		wr(REG_PSEL, 16'h0000);
		wr(REG_PORT, {FUNC_RST_ESTOP, FILT_RST, POL_NC});
		rd(REG_PORT);
		chk(got, {FUNC_RST_ESTOP, FILT_RST, 1'b0});
		wr(REG_CMD, 16'h0001);
		dly(2);
		chk({15'h0000, servo_st}, 16'h0000);
		wr(REG_PSEL, 16'h0001);
		wr(REG_PORT, {8'h00, FILT_RST, 1'b0});
		rd(REG_PORT);
		chk(got, {8'h00, FILT_RST, 1'b0});
		wr(REG_CMD, 16'h0002);
		dly(2);
		chk({15'h0000, servo_st}, 16'h0001);
		want[3] <= 1'b0;
		till(1'b1, 1'b0);
		chk({15'h0000, servo_st}, 16'h0000);
		$display("t_servo done");
	endtask
	// second reset with the motor turning for the first 40 cycles of the 50-cycle ready window
	task t_abs;
		@(posedge clk);
		want  <= 6'h27;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		dly(40);
		want[5] <= 1'b0;
		dly(DEB);
		rd(REG_ALARM);
		chk(got, {CH_A, CH_1});
		chk({15'h0000, ready}, 16'h0000);
		$display("t_abs done");
	endtask
	initial
	begin
		repeat (4000) @(posedge clk);
		failures++;
		end_sim;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_stop;
		t_ready;
		t_ot;
		t_servo;
		t_abs;
		end_sim;
	end
endmodule // servo_enable_and_input_polarity_test
